/* verilog/hqcc_host_queue_command.v */
// host queue command logic: both queue command registers on the parallel
// host port, threshold cause flags and the data port window with a tx FIFO.
// assumes pins are asynchronous to ref_clk and that a strobe stays low for
// more than four clock cycles so the three-flop filter sees it settle.
`timescale 1ns/100ps
`include "hqcc_regs.vh"

module hqcc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter ADDR_W = 4
) (
  input wire ref_clk,
  input wire reset,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output reg [WIDTH-1:0] outData,
  output reg outValid,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wrPtr, rdPtr;
  reg [ADDR_W:0] count;
  wire [ADDR_W:0] held;
  wire push, pop;

  // the output register counts toward the depth, so DEPTH words in all
  assign held = count + {{ADDR_W{1'b0}}, outValid};
  assign inReady = (held != DEPTH[ADDR_W:0]);
  assign push = inValid && inReady;
  // output stage is a register, so it refills whenever it empties
  assign pop = (count != {(ADDR_W+1){1'b0}}) && (!outValid || outReady);

  always @(posedge ref_clk) begin
    if (push) mem[wrPtr] <= inData;
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wrPtr <= {ADDR_W{1'b0}};
      rdPtr <= {ADDR_W{1'b0}};
      count <= {(ADDR_W+1){1'b0}};
      outData <= {WIDTH{1'b0}};
      outValid <= 1'b0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
        outData <= mem[rdPtr];
        outValid <= 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
endmodule

module hqcc_host_queue_command #(
  parameter FIFO_WIDTH = 16,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_ADDR_W = 4,
  parameter QLEN_W = 13,
  parameter FRM_W = 8,
  parameter BYTE_W = 16,
  parameter DUR_W = 16
) (
  input wire ref_clk,
  input wire reset,
  input wire host_address_strobe_n,
  input wire host_read_strobe_n,
  input wire host_write_strobe_n,
  input wire [11:0] hostAddr,
  input wire [1:0] hostByteEn,
  input wire [15:0] hostDataIn,
  output reg [15:0] hostDataOut,
  output reg hostDataOe,
  output reg hostTxReady,
  input wire [QLEN_W-1:0] txQueueFree,
  input wire [QLEN_W-1:0] txSizeRequest,
  input wire txFrameDone,
  output reg txEnqueueReq,
  output reg txSpaceIrq,
  output wire [FIFO_WIDTH-1:0] txMemData,
  output wire txMemValid,
  input wire txMemReady,
  input wire [FRM_W-1:0] rxFrameCount,
  input wire [FRM_W-1:0] rxFrameThreshold,
  input wire [BYTE_W-1:0] rxByteCount,
  input wire [BYTE_W-1:0] rxByteThreshold,
  input wire [DUR_W-1:0] rxDurationThreshold,
  input wire rxStatusAck,
  output reg rxThresholdIrq,
  input wire [15:0] rxReadData,
  output reg rxReadPop,
  input wire rxFrameReadDone,
  output reg rxDequeueReq,
  output reg rxHeaderPadEnable,
  input wire rxErrorReleased,
  output reg rxErrorReleaseReq
);
  localparam SYNC_W = 33;
  localparam integer TICK_INT = `HQCC_DUR_TICK_CYCLES;
  localparam [11:0] TICK_CYCLES = TICK_INT[11:0];
  // pin synchroniser: stage one feeds stage two only
  reg [SYNC_W-1:0] pinSync1, pinSync2, pinSync3;
  reg aenLow, rdLow, wrLow, rdLowPrev, wrLowPrev;
  wire [11:0] addrS;
  wire [1:0] beS;
  wire [15:0] dataS;
  wire rdStart, wrStart;
  // command state
  reg txEnqueue, txMonitor, txSpaceSeen;
  reg rxRelease, rxWindow, rxAutoDq, rxFrmEn, rxBytEn, rxDurEn;
  reg rxDurCause, rxBytCause, rxFrmCause;
  reg [11:0] tickCount;
  reg [DUR_W-1:0] durCount;
  reg [15:0] readValue;
  wire hitTx, hitRx, wrTx, wrRx, winWrite, winRead;
  wire fifoInReady, frmOver, bytOver, durOver, loByte, hiByte;

  // a strobe level counts only once stages two and three agree
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pinSync1 <= {{3{`HQCC_STROBE_RESET}}, 30'h0000000};
      pinSync2 <= {{3{`HQCC_STROBE_RESET}}, 30'h0000000};
      pinSync3 <= {{3{`HQCC_STROBE_RESET}}, 30'h0000000};
      aenLow <= 1'b0;
      rdLow <= 1'b0;
      wrLow <= 1'b0;
      rdLowPrev <= 1'b0;
      wrLowPrev <= 1'b0;
    end else begin
      pinSync1 <= {host_address_strobe_n, host_read_strobe_n, host_write_strobe_n,
                   hostAddr, hostByteEn, hostDataIn};
      pinSync2 <= pinSync1;
      pinSync3 <= pinSync2;
      if (pinSync2[32] == pinSync3[32]) aenLow <= !pinSync3[32];
      if (pinSync2[31] == pinSync3[31]) rdLow <= !pinSync3[31];
      if (pinSync2[30] == pinSync3[30]) wrLow <= !pinSync3[30];
      rdLowPrev <= rdLow;
      wrLowPrev <= wrLow;
    end
  end
  assign addrS = pinSync3[29:18];
  assign beS = pinSync3[17:16];
  assign dataS = pinSync3[15:0];
  assign rdStart = rdLow && !rdLowPrev && aenLow;
  assign wrStart = wrLow && !wrLowPrev && aenLow;

  // in window mode only the rx command register stays addressable
  assign hitRx = ({addrS[11:1], 1'b0} == `HQCC_RXQ_CMD_OFFSET);
  assign hitTx = !rxWindow && ({addrS[11:1], 1'b0} == `HQCC_TXQ_CMD_OFFSET);
  assign winWrite = wrStart && rxWindow && !hitRx;
  assign winRead = rdStart && rxWindow && !hitRx;
  assign wrTx = wrStart && hitTx;
  assign wrRx = wrStart && hitRx;
  assign loByte = beS[0] || rxWindow;
  assign hiByte = beS[1] || rxWindow;
  // window writes drop if the FIFO is full; hostTxReady warns the host
  hqcc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .ADDR_W(FIFO_ADDR_W)
  ) txFifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .inData(dataS),
    .inValid(winWrite),
    .inReady(fifoInReady),
    .outData(txMemData),
    .outValid(txMemValid),
    .outReady(txMemReady)
  );
  assign frmOver = rxFrameCount > rxFrameThreshold;
  assign bytOver = rxByteCount > rxByteThreshold;
  assign durOver = durCount > rxDurationThreshold;

  // transmit command bits: a new monitor set beats a same-cycle completion; an enqueue set is dropped while the bit is still set
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      txEnqueue <= 1'b0;
      txMonitor <= 1'b0;
      txSpaceSeen <= 1'b0;
      txEnqueueReq <= 1'b0;
      txSpaceIrq <= 1'b0;
    end else begin
      txEnqueueReq <= 1'b0;
      txSpaceIrq <= 1'b0;
      if (wrTx && loByte && dataS[`HQCC_TX_ENQUEUE_BIT] && !txEnqueue) begin
        txEnqueue <= 1'b1;
        txEnqueueReq <= 1'b1;
      end else if (txFrameDone) begin
        txEnqueue <= 1'b0;
      end
      if (wrTx && loByte && dataS[`HQCC_TX_MONITOR_BIT]) begin
        txMonitor <= 1'b1;
        txSpaceSeen <= 1'b0;
      end else if (txFrameDone) begin
        txMonitor <= 1'b0;
      end else if (txMonitor && !txSpaceSeen && txQueueFree >= txSizeRequest) begin
        txSpaceSeen <= 1'b1;
        txSpaceIrq <= 1'b1;
      end
    end
  end

  // receive command bits; reserved positions have no storage
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rxRelease <= 1'b0;
      rxWindow <= 1'b0;
      rxAutoDq <= 1'b0;
      rxFrmEn <= 1'b0;
      rxBytEn <= 1'b0;
      rxDurEn <= 1'b0;
      rxHeaderPadEnable <= 1'b0;
      rxErrorReleaseReq <= 1'b0;
    end else begin
      rxErrorReleaseReq <= 1'b0;
      if (wrRx && loByte) begin
        rxWindow <= dataS[`HQCC_RX_WINDOW_BIT];
        rxAutoDq <= dataS[`HQCC_RX_AUTODQ_BIT];
        rxFrmEn <= dataS[`HQCC_RX_FRM_EN_BIT];
        rxBytEn <= dataS[`HQCC_RX_BYT_EN_BIT];
        rxDurEn <= dataS[`HQCC_RX_DUR_EN_BIT];
      end
      if (wrRx && hiByte) begin
        rxHeaderPadEnable <= dataS[`HQCC_RX_PAD_BIT];
      end
      if (wrRx && loByte && dataS[`HQCC_RX_RELEASE_BIT] && !rxRelease) begin
        rxRelease <= 1'b1;
        rxErrorReleaseReq <= 1'b1;
      end else if (rxErrorReleased) begin
        rxRelease <= 1'b0;
      end
    end
  end

  // duration timer runs from the first queued frame until the queue drains
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tickCount <= 12'h000;
      durCount <= {DUR_W{1'b0}};
    end else if (rxFrameCount == {FRM_W{1'b0}}) begin
      tickCount <= 12'h000;
      durCount <= {DUR_W{1'b0}};
    end else if (tickCount == TICK_CYCLES - 12'h001) begin
      tickCount <= 12'h000;
      if (durCount != {DUR_W{1'b1}}) begin
        durCount <= durCount + 1'b1;
      end
    end else begin
      tickCount <= tickCount + 12'h001;
    end
  end

  // causes are snapshots, so they change only on the acknowledge
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rxDurCause <= 1'b0;
      rxBytCause <= 1'b0;
      rxFrmCause <= 1'b0;
      rxThresholdIrq <= 1'b0;
      rxDequeueReq <= 1'b0;
    end else begin
      rxThresholdIrq <= (rxFrmEn && frmOver) || (rxBytEn && bytOver)
                        || (rxDurEn && durOver);
      rxDequeueReq <= rxAutoDq && rxFrameReadDone;
      if (rxStatusAck) begin
        rxDurCause <= rxDurEn && durOver;
        rxBytCause <= rxBytEn && bytOver;
        rxFrmCause <= rxFrmEn && frmOver;
      end
    end
  end

  always @* begin
    readValue = 16'h0000;
    if (hitTx) begin
      readValue[`HQCC_TX_ENQUEUE_BIT] = txEnqueue;
      readValue[`HQCC_TX_MONITOR_BIT] = txMonitor;
    end else if (hitRx) begin
      // window bit and reserved bits stay zero
      readValue[`HQCC_RX_RELEASE_BIT] = rxRelease;
      readValue[`HQCC_RX_AUTODQ_BIT] = rxAutoDq;
      readValue[`HQCC_RX_FRM_EN_BIT] = rxFrmEn;
      readValue[`HQCC_RX_BYT_EN_BIT] = rxBytEn;
      readValue[`HQCC_RX_DUR_EN_BIT] = rxDurEn;
      readValue[`HQCC_RX_PAD_BIT] = rxHeaderPadEnable;
      readValue[`HQCC_RX_FRM_CAUSE_BIT] = rxFrmCause;
      readValue[`HQCC_RX_BYT_CAUSE_BIT] = rxBytCause;
      readValue[`HQCC_RX_DUR_CAUSE_BIT] = rxDurCause;
    end
  end

  // read path: data is held for the whole strobe
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hostDataOut <= 16'h0000;
      hostDataOe <= 1'b0;
      rxReadPop <= 1'b0;
      hostTxReady <= 1'b0;
    end else begin
      rxReadPop <= winRead;
      hostTxReady <= fifoInReady;
      hostDataOe <= rdLow && aenLow;
      if (winRead) begin
        hostDataOut <= rxReadData;
      end else if (rdStart) begin
        hostDataOut <= readValue;
      end
    end
  end
endmodule

/* common/hqcc_regs.vh */
// register offsets, field positions, reset values and timing counts for
// the host queue command block; definitions only, included by bare name
`ifndef HQCC_REGS_VH
`define HQCC_REGS_VH

// byte offsets on the parallel host port
`define HQCC_TXQ_CMD_OFFSET 12'h180
`define HQCC_RXQ_CMD_OFFSET 12'h182

// transmit_queue_command fields
`define HQCC_TX_ENQUEUE_BIT 0
`define HQCC_TX_MONITOR_BIT 1

// receive_queue_command fields
`define HQCC_RX_RELEASE_BIT 0
`define HQCC_RX_WINDOW_BIT 3
`define HQCC_RX_AUTODQ_BIT 4
`define HQCC_RX_FRM_EN_BIT 5
`define HQCC_RX_BYT_EN_BIT 6
`define HQCC_RX_DUR_EN_BIT 7
`define HQCC_RX_PAD_BIT 9
`define HQCC_RX_FRM_CAUSE_BIT 10
`define HQCC_RX_BYT_CAUSE_BIT 11
`define HQCC_RX_DUR_CAUSE_BIT 12

// reset values
`define HQCC_CMD_RESET 16'h0000
`define HQCC_STROBE_RESET 1'b1

// duration timer tick: clock period and tick length in ns
`define HQCC_CLK_PERIOD_NS 8
`define HQCC_DUR_TICK_NS 1000
`define HQCC_DUR_TICK_CYCLES (`HQCC_DUR_TICK_NS / `HQCC_CLK_PERIOD_NS)

`endif

/* dv/hqcc_props.sv */
// checker for the host queue command block, bound to every instance
// assumes default widths and the design's ref_clk and async reset
`timescale 1ns/100ps
module hqcc_props (
  input wire ref_clk,
  input wire reset,
  input wire host_write_strobe_n,
  input wire [12:0] txQueueFree,
  input wire [12:0] txSizeRequest,
  input wire txEnqueueReq,
  input wire txSpaceIrq,
  input wire [15:0] txMemData,
  input wire txMemValid,
  input wire txMemReady,
  input wire [7:0] rxFrameCount,
  input wire [15:0] rxByteCount,
  input wire [15:0] rxByteThreshold,
  input wire rxThresholdIrq,
  input wire rxFrameReadDone,
  input wire rxDequeueReq,
  input wire rxHeaderPadEnable,
  input wire rxErrorReleaseReq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire fits = txQueueFree >= txSizeRequest;
  wire noFrames = rxFrameCount == 8'h00;
  // duration counter is zeroed one cycle behind, so two empty cycles needed
  wire calm = noFrames && !(rxByteCount > rxByteThreshold);
  chk_enq_one_frame: assert property (
    txEnqueueReq |-> !$past(host_write_strobe_n, 3) ##1 !txEnqueueReq)
    else $error("enqueue request without a write or too long");
  chk_space_fits: assert property (txSpaceIrq |-> $past(fits))
    else $error("space interrupt while request does not fit");
  chk_space_pulse: assert property (txSpaceIrq |=> !txSpaceIrq)
    else $error("space interrupt longer than one cycle");
  chk_irq_quiet: assert property (calm && $past(noFrames) |=> !rxThresholdIrq)
    else $error("rx interrupt with nothing over threshold");
  chk_dequeue_cause: assert property (rxDequeueReq |-> $past(rxFrameReadDone))
    else $error("dequeue without a completed frame read");
  chk_release_pulse: assert property (
    rxErrorReleaseReq |-> !$past(host_write_strobe_n, 3) ##1 !rxErrorReleaseReq)
    else $error("release request without a write or too long");
  chk_mem_hold: assert property (
    txMemValid && !txMemReady |=> txMemValid && $stable(txMemData))
    else $error("frame buffer word dropped while stalled");
  chk_pad_write: assert property (
    $changed(rxHeaderPadEnable) |-> !$past(host_write_strobe_n, 3))
    else $error("pad enable changed without a write");
  cover property (txSpaceIrq);
  cover property (rxThresholdIrq);
  cover property (rxDequeueReq);
  cover property (txMemValid && !txMemReady);
endmodule
bind hqcc_host_queue_command hqcc_props chk (.*);

/* dv/hqcc_host_model.sv */
// host processor model driving the parallel host pins
// assumes the device filters strobes over about five ref_clk cycles
`timescale 1ns/100ps
module hqcc_host_model (
  input wire ref_clk,
  input wire [15:0] hostDataOut,
  input wire hostDataOe,
  output logic host_address_strobe_n = 1'b1,
  output logic host_read_strobe_n = 1'b1,
  output logic host_write_strobe_n = 1'b1,
  output logic [11:0] hostAddr = 12'h000,
  output logic [1:0] hostByteEn = 2'h0,
  output logic [15:0] hostDataIn = 16'h0000
);
  // output enable as seen while the read strobe still stands
  logic oeSample = 1'b0;
  // strobes low 8 and high 6 cycles, above the filter's minimum of five
  task automatic acc(input bit wr, input logic [11:0] a, input logic [15:0] d,
      input logic [1:0] be, output logic [15:0] q);
    @(negedge ref_clk);
    hostAddr = a;
    hostByteEn = be;
    hostDataIn = d;
    host_address_strobe_n = 1'b0;
    host_read_strobe_n = wr;
    host_write_strobe_n = !wr;
    repeat (8) @(negedge ref_clk);
    q = hostDataOut;
    oeSample = hostDataOe;
    host_address_strobe_n = 1'b1;
    host_read_strobe_n = 1'b1;
    host_write_strobe_n = 1'b1;
    // released lines must not keep showing the old value
    hostAddr = ~a;
    hostDataIn = ~d;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule

/* dv/hqcc_host_queue_command_test.sv */
// self-checking bench for the host queue command block
// assumes the host model on the pins; queues and memories are modelled here
`timescale 1ns/100ps
module hqcc_host_queue_command_test;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  wire host_address_strobe_n, host_read_strobe_n, host_write_strobe_n;
  wire [11:0] hostAddr;
  wire [1:0] hostByteEn;
  wire [15:0] hostDataIn, hostDataOut, txMemData;
  wire hostDataOe, hostTxReady, txEnqueueReq, txSpaceIrq, txMemValid, rxThresholdIrq;
  wire rxReadPop, rxDequeueReq, rxHeaderPadEnable, rxErrorReleaseReq;
  logic [12:0] txQueueFree = 13'h0000;
  logic [12:0] txSizeRequest = 13'h0000;
  logic txFrameDone = 1'b0, txMemReady = 1'b0, rxStatusAck = 1'b0;
  logic rxFrameReadDone = 1'b0, rxErrorReleased = 1'b0;
  logic [7:0] rxFrameCount = 8'h00, rxFrameThreshold = 8'hFF;
  logic [15:0] rxByteCount = 16'h0000, rxByteThreshold = 16'hFFFF;
  logic [15:0] rxDurationThreshold = 16'h0002, rxReadData = 16'h0000, q, d;
  logic [15:0] fq[$];
  int failCount = 0, compares = 0, cyc = 0, nEnq = 0, nSpace = 0, nDeq = 0, nRel = 0, nPop = 0;
  hqcc_host_model host (.*);
  hqcc_host_queue_command DUT (.*);
  initial forever #4 ref_clk = ~ref_clk;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tallyAndFinish;
    $display("comparisons %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    host.acc(1'b1, a, v, 2'h3, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    host.acc(1'b0, a, 16'h0000, 2'h3, q);
    cmp(q, e);
    cmp({15'h0000, host.oeSample}, 16'h0001);
    cmp({15'h0000, hostDataOe}, 16'h0000);
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    nEnq += txEnqueueReq;
    nSpace += txSpaceIrq;
    nDeq += rxDequeueReq;
    nRel += rxErrorReleaseReq;
    nPop += rxReadPop;
    if ((txMemValid && txMemReady) === 1'b1) cmp(txMemData, fq.pop_front());
    if (cyc == 20000) begin
      failCount++;
      tallyAndFinish;
    end
  end
  initial begin
    void'($urandom(32'h17A2));
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    rd(12'h180, 16'h0000);
    rd(12'h182, 16'h0000);
    rd(12'h188, 16'h0000);
    $display("test reset values done");
    wr(12'h180, 16'hFFF9);
    rd(12'h180, 16'h0001);
    cmp(16'(nEnq), 16'h0001);
    pulse(txFrameDone);
    rd(12'h180, 16'h0000);
    $display("test enqueue done");
    txSizeRequest = 13'($urandom_range(4000, 100));
    txQueueFree = txSizeRequest - 13'h0001;
    wr(12'h180, 16'h0002);
    rd(12'h180, 16'h0002);
    cmp(16'(nSpace), 16'h0000);
    txQueueFree = txSizeRequest;
    repeat (20) @(negedge ref_clk);
    pulse(txFrameDone);
    rd(12'h180, 16'h0000);
    cmp(16'(nSpace), 16'h0001);
    $display("test space monitor done");
    for (int k = 0; k < 3; k++) begin
      rxFrameThreshold = 8'($urandom_range(200));
      rxByteThreshold = 16'($urandom_range(60000));
      rxFrameCount = (k == 0) ? rxFrameThreshold + 8'h01 : 8'(k / 2);
      rxByteCount = (k == 1) ? rxByteThreshold + 16'h0001 : rxByteThreshold;
      repeat (k == 2 ? 400 : 3) @(negedge ref_clk);
      cmp({15'h0000, rxThresholdIrq}, 16'h0000);
      wr(12'h182, 16'h0020 << k);
      cmp({15'h0000, rxThresholdIrq}, 16'h0001);
      pulse(rxStatusAck);
      rd(12'h182, (16'h0020 << k) | (16'h0400 << k));
      rxFrameCount = 8'h00;
      rxByteCount = 16'h0000;
      rd(12'h182, (16'h0020 << k) | (16'h0400 << k));
    end
    pulse(rxStatusAck);
    rd(12'h182, 16'h0080);
    $display("test thresholds done");
    wr(12'h182, 16'h0018);
    rd(12'h182, 16'h0010);
    for (int i = 0; i < 17; i++) begin
      d = 16'($urandom);
      if (i < 16) fq.push_back(d);
      host.acc(1'b1, 12'h180, d, 2'h0, q);
    end
    cmp({15'h0000, hostTxReady}, 16'h0000);
    cmp(16'(nEnq), 16'h0001);
    repeat (60) @(negedge ref_clk) txMemReady = 1'($urandom);
    txMemReady = 1'b1;
    repeat (20) @(negedge ref_clk);
    cmp(16'(fq.size()), 16'h0000);
    cmp({15'h0000, hostTxReady}, 16'h0001);
    rxReadData = 16'($urandom); // random word on the modelled rx read data port
    host.acc(1'b0, 12'h0A4, 16'h0000, 2'h0, q);
    cmp(q, rxReadData);
    cmp(16'(nPop), 16'h0001);
    pulse(rxFrameReadDone);
    repeat (2) @(negedge ref_clk);
    cmp(16'(nDeq), 16'h0001);
    wr(12'h182, 16'h0000);
    rd(12'h180, 16'h0000);
    pulse(rxFrameReadDone);
    repeat (2) @(negedge ref_clk);
    cmp(16'(nDeq), 16'h0001);
    $display("test data window done");
    wr(12'h182, 16'h0201);
    cmp({15'h0000, rxHeaderPadEnable}, 16'h0001);
    rd(12'h182, 16'h0201);
    cmp(16'(nRel), 16'h0001);
    pulse(rxErrorReleased);
    rd(12'h182, 16'h0200);
    $display("test release and pad done");
    tallyAndFinish;
  end
endmodule
